// ### logic/tfr_framer.sv
// T1 framer for one link: F4, ESF and F12 receive alignment and transmit.
// Contract
// [R1] Per-link format select: F4, ESF or F12.
// [R2] F4 frames 1 and 3 carry 1, 0.
// [R3] F4 frames 2 and 4 F-bit are service.
// [R4] F4 yellow alarm forces channel bit 2 low.
// [R5] F4 syncs on definite candidate or forced lock.
// [R6] ESF multiframe is 24 frames.
// [R7] ESF F-bits: link, check bits, pattern.
// [R8] Pattern 001011 sent and searched every fourth frame.
// [R9] Frame 1 first, bit 1 first.
// [R10] ESF sync lost on framing or check errors.
// [R11] Force resync in sync restarts the search.
// [R12] First mode: sync on single definite candidate.
// [R13] First mode forced resync locks next candidate.
// [R14] Second mode needs candidate plus good check.
// [R15] Second mode forced resync starts fresh search.
// [R16] Check covers data with F-bits as ones.
// [R17] Check of multiframe N sent in N+1.
// [R18] Remainder from x6 multiply, x6+x+1 divide.
// [R19] c1 is remainder MSB, c6 LSB.
// [R20] Receive compares against next multiframe check bits.
// [R21] Check mismatch in sync counts and flags.
// [R22] Frames are 193 bits, F-bit first.
// [R23] Error counter is 16 bits, saturating.
`timescale 1ns/100ps
`default_nettype none
module tfr_framer #(
   parameter int CNT_W = tfr_pkg::CRC_CNT_W
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire tfr_pkg::tfr_bus_t I_BUS,
   output logic [tfr_pkg::DATA_W-1:0] O_RDATA,
   input wire tfr_pkg::tfr_line_t I_RX,
   input wire tfr_pkg::tfr_line_t I_TX,
   output tfr_pkg::tfr_line_t O_TX,
   output logic O_TX_FBIT,
   output logic O_SYNC
);
   import tfr_pkg::*;

   typedef struct packed {
      tfr_fsm_t state;
      logic [1:0] fmt;
      logic mode;
      logic yel;
      logic [7:0] pos;
      logic [4:0] frm;
      logic slip;
      logic lock;
      logic [5:0] hist;
      logic [2:0] cnt;
      logic [4:0] errh;
      logic [1:0] mferr;
      logic [2:0] crcbad;
      logic [5:0] chk;
      logic [5:0] rem;
      logic [1:0] have;
      logic crcflag;
      logic [7:0] tpos;
      logic [4:0] tfrm;
      logic [5:0] tcrc;
      tfr_line_t tx;
      logic txf;
      logic sync;
      logic [DATA_W-1:0] rdata;
   } tfr_state_t;

   tfr_state_t s_q;
   tfr_state_t s_d;
   logic [4:0] fmax;
   logic rx_fbit;
   logic rx_chk;
   logic rx_exp;
   logic rx_err;
   logic [5:0] hist_new;
   logic [2:0] need;
   logic hit;
   logic [4:0] hit_frm;
   logic esf;
   logic rx_bound;
   logic rx_crc_en;
   logic rx_crc_bit;
   logic [5:0] rx_rem;
   logic tx_fb;
   logic tx_bit;
   logic tx_start;
   logic [5:0] tx_rem;
   logic crc_inc;
   logic crc_bad;
   logic [4:0] errh_new;
   logic [CNT_W-1:0] crc_count;

   // Back to the search with the pattern memory and candidates dropped.
   function automatic tfr_state_t to_hunt(input tfr_state_t s,
                                          input logic slip);
      tfr_state_t r;
      r = s;
      r.state = ST_HUNT;
      r.hist = '0;
      r.cnt = '0;
      r.errh = '0;
      r.mferr = '0;
      r.crcbad = '0;
      r.have = '0;
      r.lock = 1'b0;
      r.slip = slip;
      return r;
   endfunction

   assign esf = (s_q.fmt == FMT_ESF);
   assign rx_fbit = (s_q.pos == 8'h00); // [R22]
   assign rx_bound = rx_fbit && (s_q.frm == 5'h00);
   assign rx_crc_en = I_RX.valid && esf && (s_q.state != ST_HUNT);
   assign rx_crc_bit = rx_fbit ? 1'b1 : I_RX.data; // [R16]
   assign tx_start = (s_q.tpos == 8'h00) && (s_q.tfrm == 5'h00);

   tfr_crc6 u_rx_crc (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_en(rx_crc_en),
      .i_start(rx_bound),
      .i_bit(rx_crc_bit),
      .o_rem(rx_rem)
   );

   tfr_crc6 u_tx_crc (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_en(I_TX.valid),
      .i_start(tx_start),
      .i_bit(tx_fb ? 1'b1 : tx_bit), // [R16]
      .o_rem(tx_rem)
   );

   tfr_satcnt #(
      .W(CNT_W)
   ) u_crc_cnt (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_inc(crc_inc),
      .o_count(crc_count)
   );

   always_comb begin
      unique case (s_q.fmt) // [R1]
         FMT_ESF: fmax = FRM_LAST_ESF; // [R6]
         FMT_F12: fmax = FRM_LAST_F12;
         default: fmax = FRM_LAST_F4;
      endcase
   end

   // Candidate test over the pattern memory.
   always_comb begin
      hist_new = {s_q.hist[4:0], I_RX.data};
      hit = 1'b0;
      hit_frm = 5'h00;
      if (esf) begin
         need = FPS_NEED;
         rx_chk = (s_q.frm[1:0] == 2'h3);
         rx_exp = FPS_PATTERN[FPS_LAST - s_q.frm[4:2]]; // [R8]
         for (int k = 0; k < 6; k++) begin
            if (hist_new == 6'({FPS_PATTERN, FPS_PATTERN} >> (6 - k))) begin
               hit = 1'b1;
               hit_frm = 5'(4 * ((5 + k) % 6) + 3); // [R8]
            end
         end
      end else begin
         need = FT_NEED;
         rx_chk = ~s_q.frm[0];
         rx_exp = ~s_q.frm[1]; // [R2]
         if (hist_new[3:0] == FT_ALT_NEW0) begin
            hit = 1'b1;
            hit_frm = FT_FRM_NEW0;
         end else if (hist_new[3:0] == FT_ALT_NEW1) begin
            hit = 1'b1;
            hit_frm = FT_FRM_NEW1;
         end
      end
      rx_err = (I_RX.data != rx_exp);
      errh_new = {s_q.errh[3:0], rx_err};
   end

   // Transmit bit selection.
   always_comb begin
      tx_fb = (s_q.tpos == 8'h00);
      tx_bit = I_TX.data;
      if (tx_fb) begin
         if (esf) begin
            unique case (s_q.tfrm[1:0]) // [R7]
               2'h1: tx_bit = s_q.tcrc[FPS_LAST - s_q.tfrm[4:2]]; // [R19]
               2'h3: tx_bit = FPS_PATTERN[FPS_LAST - s_q.tfrm[4:2]]; // [R8]
               default: tx_bit = I_TX.data;
            endcase
         end else if (!s_q.tfrm[0]) begin // [R3]
            tx_bit = ~s_q.tfrm[1]; // [R2]
         end
      end else if (s_q.yel && (s_q.fmt == FMT_F4)
                   && (s_q.tpos[2:0] == CH_BIT2)) begin
         tx_bit = 1'b0; // [R4]
      end
   end

   always_comb begin
      s_d = s_q;
      crc_inc = 1'b0;
      crc_bad = (s_q.chk != s_q.rem); // [R20]
      if (I_BUS.wr && (I_BUS.addr == OFS_STATUS)
          && I_BUS.wdata[STAT_CRCERR_BIT]) begin
         s_d.crcflag = 1'b0;
      end
      if (I_RX.valid) begin
         if (s_q.slip) begin
            s_d.slip = 1'b0;
         end else if (s_q.pos == POS_LAST) begin
            s_d.pos = 8'h00; // [R22]
            s_d.frm = (s_q.frm == fmax) ? 5'h00 : s_q.frm + 5'h01;
         end else begin
            s_d.pos = s_q.pos + 8'h01;
         end
         if (rx_fbit && esf && (s_q.frm[1:0] == 2'h1)) begin
            s_d.chk = {s_q.chk[4:0], I_RX.data}; // [R20]
         end
         if (rx_fbit && rx_chk) begin
            unique case (s_q.state)
               ST_HUNT: begin
                  s_d.hist = hist_new;
                  s_d.cnt = s_q.cnt + 3'h1;
                  if (s_q.cnt + 3'h1 == need) begin
                     if (hit) begin
                        s_d.frm = hit_frm;
                        s_d.lock = 1'b0;
                        s_d.have = '0;
                        s_d.errh = '0;
                        // A forced lock skips the check confirmation.
                        if (!s_q.mode || s_q.lock || !esf) begin
                           s_d.state = ST_SYNC; // [R5] [R12] [R13]
                        end else begin
                           s_d.state = ST_CONF; // [R14]
                        end
                     end else begin
                        s_d = to_hunt(s_d, 1'b1); // [R12]
                        s_d.lock = s_q.lock;
                     end
                  end
               end
               ST_CONF: begin
                  if (rx_err) begin
                     s_d = to_hunt(s_d, 1'b1); // [R14]
                  end
               end
               ST_SYNC: begin
                  s_d.errh = errh_new;
                  if (rx_err && esf) begin
                     s_d.mferr = s_q.mferr + 2'h1;
                  end
                  if ((errh_new[0] && (errh_new[4:1] != 4'h0))
                      || (rx_err && esf
                          && (s_q.mferr + 2'h1 == MF_ERR_LIMIT))) begin
                     s_d = to_hunt(s_d, 1'b0); // [R10]
                  end
               end
               default: s_d = to_hunt(s_d, 1'b0);
            endcase
         end
         if (rx_bound && esf && (s_q.state != ST_HUNT)) begin
            s_d.rem = rx_rem;
            s_d.mferr = '0;
            if (s_q.have != HAVE_FULL) begin
               s_d.have = s_q.have + 2'h1;
            end else if (s_q.state == ST_CONF) begin
               if (crc_bad) begin
                  s_d = to_hunt(s_d, 1'b1); // [R14]
               end else begin
                  s_d.state = ST_SYNC; // [R14]
               end
            end else if (crc_bad) begin
               crc_inc = 1'b1; // [R21]
               s_d.crcflag = 1'b1; // [R21]
               s_d.crcbad = s_q.crcbad + 3'h1;
               if (s_q.crcbad + 3'h1 == CRC_BAD_LIMIT) begin
                  s_d = to_hunt(s_d, 1'b0); // [R10]
               end
            end else begin
               s_d.crcbad = '0;
            end
         end
      end
      if (I_BUS.wr && (I_BUS.addr == OFS_CTRL)) begin
         s_d.fmt = I_BUS.wdata[CTRL_FMT_LSB +: 2]; // [R1]
         s_d.mode = I_BUS.wdata[CTRL_MODE_BIT];
         s_d.yel = I_BUS.wdata[CTRL_YEL_BIT];
         if (I_BUS.wdata[CTRL_FMT_LSB +: 2] != s_q.fmt) begin
            s_d = to_hunt(s_d, 1'b0);
         end
      end
      if (I_BUS.wr && (I_BUS.addr == OFS_CMD)
          && I_BUS.wdata[CMD_RESYNC_BIT]) begin
         s_d = to_hunt(s_d, 1'b0); // [R11] [R15]
         if (!s_q.mode && (s_q.state != ST_SYNC)) begin
            s_d.lock = 1'b1; // [R13]
         end
      end
      s_d.tx.valid = I_TX.valid;
      if (I_TX.valid) begin
         s_d.tx.data = tx_bit; // [R9]
         s_d.txf = tx_fb;
         if (tx_start) begin
            s_d.tcrc = tx_rem; // [R17]
         end
         if (s_q.tpos == POS_LAST) begin
            s_d.tpos = 8'h00;
            s_d.tfrm = (s_q.tfrm == fmax) ? 5'h00 : s_q.tfrm + 5'h01;
         end else begin
            s_d.tpos = s_q.tpos + 8'h01;
         end
      end
      s_d.sync = (s_d.state == ST_SYNC);
      s_d.rdata = '0;
      if (I_BUS.rd) begin
         unique case (I_BUS.addr)
            OFS_CTRL: begin
               s_d.rdata[CTRL_FMT_LSB +: 2] = s_q.fmt;
               s_d.rdata[CTRL_MODE_BIT] = s_q.mode;
               s_d.rdata[CTRL_YEL_BIT] = s_q.yel;
            end
            OFS_STATUS: begin
               s_d.rdata[STAT_SYNC_BIT] = s_q.sync;
               s_d.rdata[STAT_CRCERR_BIT] = s_q.crcflag;
               s_d.rdata[STAT_CONF_BIT] = (s_q.state == ST_CONF);
            end
            OFS_CRC_CNT: s_d.rdata = DATA_W'(crc_count); // [R21]
            default: s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         s_q <= '0;
         s_q.state <= ST_HUNT;
         s_q.fmt <= CTRL_FMT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign O_RDATA = s_q.rdata;
   assign O_TX = s_q.tx;
   assign O_TX_FBIT = s_q.txf;
   assign O_SYNC = s_q.sync;
endmodule // tfr_framer
`default_nettype wire

// ### logic/tfr_pkg.sv
// Package of constants and types for the T1 framer block.
`default_nettype none
package tfr_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CMD = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_CRC_CNT = 4'hC;
   localparam int CTRL_FMT_LSB = 0;
   localparam int CTRL_MODE_BIT = 2;
   localparam int CTRL_YEL_BIT = 3;
   localparam int CMD_RESYNC_BIT = 0;
   localparam int STAT_SYNC_BIT = 0;
   localparam int STAT_CRCERR_BIT = 1;
   localparam int STAT_CONF_BIT = 2;
   localparam logic [1:0] FMT_F4 = 2'h0;
   localparam logic [1:0] FMT_ESF = 2'h1;
   localparam logic [1:0] FMT_F12 = 2'h2;
   localparam logic [1:0] CTRL_FMT_RST = FMT_ESF;
   localparam logic [7:0] POS_LAST = 8'hC0;
   localparam logic [4:0] FRM_LAST_F4 = 5'h03;
   localparam logic [4:0] FRM_LAST_ESF = 5'h17;
   localparam logic [4:0] FRM_LAST_F12 = 5'h0B;
   localparam logic [5:0] FPS_PATTERN = 6'h0B;
   localparam logic [2:0] FPS_LAST = 3'h5;
   localparam logic [2:0] FPS_NEED = 3'h6;
   localparam logic [2:0] FT_NEED = 3'h4;
   localparam logic [3:0] FT_ALT_NEW0 = 4'hA;
   localparam logic [3:0] FT_ALT_NEW1 = 4'h5;
   localparam logic [4:0] FT_FRM_NEW0 = 5'h02;
   localparam logic [4:0] FT_FRM_NEW1 = 5'h00;
   localparam logic [2:0] CH_BIT2 = 3'h2;
   localparam logic [5:0] CRC_POLY = 6'h03;
   localparam int CRC_CNT_W = 16;
   localparam logic [2:0] CRC_BAD_LIMIT = 3'h4;
   localparam logic [1:0] MF_ERR_LIMIT = 2'h2;
   localparam logic [1:0] HAVE_FULL = 2'h2;

   typedef enum logic [2:0] {
      ST_HUNT = 3'b001,
      ST_CONF = 3'b010,
      ST_SYNC = 3'b100
   } tfr_fsm_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tfr_bus_t;

   typedef struct packed {
      logic valid;
      logic data;
   } tfr_line_t;
endpackage
`default_nettype wire

// ### logic/tfr_crc6.sv
// Serial CRC-6 engine, generator x6+x+1, most significant bit first.
`timescale 1ns/100ps
`default_nettype none
module tfr_crc6 (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_en,
   input wire logic i_start,
   input wire logic i_bit,
   output logic [5:0] o_rem
);
   import tfr_pkg::*;

   typedef struct packed {
      logic [5:0] rem;
   } tfr_crc_st_t;

   tfr_crc_st_t s_q;
   tfr_crc_st_t s_d;
   logic [5:0] base;
   logic fb;

   // Multiplying by x6 is implicit: the data bit meets the top stage.
   always_comb begin
      s_d = s_q;
      base = i_start ? 6'h00 : s_q.rem;
      fb = i_bit ^ base[5];
      if (i_en) begin
         s_d.rem = {base[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00); // [R18]
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rem = s_q.rem;
endmodule // tfr_crc6
`default_nettype wire

// ### logic/tfr_satcnt.sv
// Saturating event counter.
`timescale 1ns/100ps
`default_nettype none
module tfr_satcnt #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_inc,
   output logic [W-1:0] o_count
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tfr_cnt_st_t;

   tfr_cnt_st_t s_q;
   tfr_cnt_st_t s_d;

   // Stopping at all ones keeps a flood of errors from reading as few.
   always_comb begin
      s_d = s_q;
      if (i_inc && (s_q.cnt != {W{1'b1}})) begin
         s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1}; // [R23]
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_count = s_q.cnt;
endmodule // tfr_satcnt
`default_nettype wire

// ### sim/tfr_line_far.sv
// Far-end line model sending an ESF stream with true framing and check bits, the check bits inverted while i_bad is high.
`timescale 1ns/100ps
`default_nettype none
module tfr_line_far (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_bad,
   output tfr_pkg::tfr_line_t o_line
);
   import tfr_pkg::*;
   logic [7:0] b_q;
   logic [4:0] f_q;
   logic [5:0] crc_q;
   logic [5:0] prev_q;
   logic [5:0] crc_d;
   logic v;
   always_comb begin
      v = b_q[2] ^ f_q[0];
      if (b_q == 8'h00) begin
         if (f_q[1:0] == 2'h3) begin
            v = FPS_PATTERN[3'h5 - f_q[4:2]];
         end else if (f_q[1:0] == 2'h1) begin
            v = prev_q[3'h5 - f_q[4:2]] ^ i_bad;
         end else begin
            v = 1'b0;
         end
      end
      crc_d = {crc_q[4:0], 1'b0}
         ^ ((crc_q[5] ^ (v | ~|b_q)) ? CRC_POLY : 6'h00);
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         b_q <= 8'h00;
         f_q <= 5'h00;
         crc_q <= 6'h00;
         prev_q <= 6'h00;
         o_line <= '0;
      end else begin
         o_line <= '{valid: 1'b1, data: v};
         b_q <= (b_q == POS_LAST) ? 8'h00 : b_q + 8'h01;
         crc_q <= crc_d;
         if (b_q == POS_LAST) begin
            f_q <= (f_q == FRM_LAST_ESF) ? 5'h00 : f_q + 5'h01;
            if (f_q == FRM_LAST_ESF) begin
               prev_q <= crc_d;
               crc_q <= 6'h00;
            end
         end
      end
   end
endmodule // tfr_line_far
`default_nettype wire

// ### sim/tfr_framer_asserts.sv
// Port-level timing checks of the T1 framer.
`timescale 1ns/100ps
`default_nettype none
module tfr_framer_asserts #(
   parameter int CNT_W = 16
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire tfr_pkg::tfr_bus_t I_BUS,
   input wire logic [tfr_pkg::DATA_W-1:0] O_RDATA,
   input wire tfr_pkg::tfr_line_t I_RX,
   input wire tfr_pkg::tfr_line_t I_TX,
   input wire tfr_pkg::tfr_line_t O_TX,
   input wire logic O_TX_FBIT,
   input wire logic O_SYNC
);
   import tfr_pkg::*;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   logic [7:0] pos_q;
   logic [12:0] seen_q;
   logic [1:0] fmt_q;
   // A forced lock may skip the check confirmation, so the count is parked there.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pos_q <= POS_LAST;
         seen_q <= 13'h0000;
         fmt_q <= CTRL_FMT_RST;
      end else begin
         if (O_TX.valid) begin
            pos_q <= (pos_q == POS_LAST) ? 8'h00 : pos_q + 8'h01;
         end
         if (I_BUS.wr && I_BUS.addr == OFS_CTRL) begin
            fmt_q <= I_BUS.wdata[1:0];
            seen_q <= 13'h0000;
         end else if (I_BUS.wr && I_BUS.addr == OFS_CMD) begin
            seen_q <= 13'h1FFF;
         end else if ($fell(O_SYNC)) begin
            seen_q <= 13'h0000;
         end else if (I_RX.valid && seen_q != 13'h1FFF) begin
            seen_q <= seen_q + 13'h0001;
         end
      end
   end
   sequence rd_at(logic [3:0] a);
      I_BUS.rd && I_BUS.addr == a;
   endsequence
   sequence wr_at(logic [3:0] a);
      I_BUS.wr && I_BUS.addr == a;
   endsequence
   tx_echo_a: assert property (O_TX.valid == $past(I_TX.valid))
      else $error("transmit bit not one cycle after request");
   fbit_place_a: assert property (
      O_TX.valid |-> O_TX_FBIT == (pos_q == POS_LAST))
      else $error("framing bit flag not every 193 bits");
   fbit_valid_a: assert property (O_TX_FBIT |-> O_TX.valid)
      else $error("framing bit flag without a bit");
   cnt_width_a: assert property (
      rd_at(OFS_CRC_CNT) |=> (O_RDATA >> CNT_W) == '0)
      else $error("error count wider than its field");
   resync_drop_a: assert property (
      wr_at(OFS_CMD) and I_BUS.wdata[CMD_RESYNC_BIT] |-> ##[1:2] !O_SYNC)
      else $error("sync kept after forced resync");
   // Only a change of format restarts the search; a rewrite keeps sync.
   fmt_restart_a: assert property (
      wr_at(OFS_CTRL) and (I_BUS.wdata[1:0] != fmt_q) |-> ##[1:2] !O_SYNC)
      else $error("sync kept after format write");
   sync_cause_a: assert property ($rose(O_SYNC) |-> $past(I_RX.valid))
      else $error("sync rose without a received bit");
   hunt_len_a: assert property (
      $rose(O_SYNC) && fmt_q == FMT_ESF |-> seen_q >= 13'h0F14)
      else $error("sync found before six pattern bits");
endmodule // tfr_framer_asserts
bind tfr_framer tfr_framer_asserts #(.CNT_W(CNT_W)) u_chk (
   .I_CLK(I_CLK), .I_RST(I_RST),
   .I_BUS(I_BUS), .O_RDATA(O_RDATA), .I_RX(I_RX), .I_TX(I_TX), .O_TX(O_TX),
   .O_TX_FBIT(O_TX_FBIT), .O_SYNC(O_SYNC));
`default_nettype wire

// ### sim/tfr_framer_test.sv
// Self-checking bench of the T1 framer against a far-end line model.
`timescale 1ns/100ps
`default_nettype none
module tfr_framer_test;
   import tfr_pkg::*;
   logic clk, rst, bad, tx_on, fmt_f4, ex, mok;
   tfr_bus_t bus;
   tfr_line_t rx, tx, tx_out;
   logic [DATA_W-1:0] rdata;
   logic fbit, sync;
   int err_total, check_count, cyc, n;
   logic [7:0] mb;
   logic [4:0] mf;
   logic [5:0] mcrc, mprev;
   tfr_framer u_dut (.I_CLK(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata),
      .I_RX(rx), .I_TX(tx), .O_TX(tx_out), .O_TX_FBIT(fbit), .O_SYNC(sync));
   tfr_line_far u_far (.i_clk(clk), .i_rst(rst), .i_bad(bad), .o_line(rx));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) tx <= '{valid: tx_on, data: 1'b1};
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // Every transmitted bit but the first multiframe's check bits is predicted from position; payload is all ones.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mb = 8'h00;
         mf = 5'h00;
         mcrc = 6'h00;
         mok = 1'b0;
      end else if (tx_out.valid) begin
         ex = 1'b1;
         if (fmt_f4) begin
            if (mb == 8'h00) ex = mf[0] | ~mf[1];
            else if (mb[2:0] == 3'h2) ex = 1'b0;
         end else if (mb == 8'h00 && mf[1:0] == 2'h3) begin
            ex = FPS_PATTERN[3'h5 - mf[4:2]];
         end else if (mb == 8'h00 && mf[1:0] == 2'h1) begin
            ex = mok ? mprev[3'h5 - mf[4:2]] : tx_out.data;
         end
         chk(tx_out.data, ex);
         chk(fbit, mb == 8'h00);
         mcrc = {mcrc[4:0], 1'b0}
            ^ ((mcrc[5] ^ (tx_out.data | ~|mb)) ? CRC_POLY : 6'h00);
         mb = (mb == POS_LAST) ? 8'h00 : mb + 8'h01;
         if (mb == 8'h00) begin
            mf = mf + 5'h01;
            if (mf == (fmt_f4 ? 5'h04 : 5'h18)) begin
               mf = 5'h00;
               mprev = mcrc;
               mcrc = 6'h00;
               mok = 1'b1;
            end
         end
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus <= '0;
      #1 chk(rdata, e);
   endtask
   task automatic wait_sync(input logic lvl, input int lim);
      n = 0;
      while (sync !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(sync, lvl);
   endtask
   task automatic do_reset;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic t_regs;
      rd_chk(OFS_CTRL, 32'(CTRL_FMT_RST));
      rd_chk(OFS_STATUS, 32'h0);
      rd_chk(OFS_CRC_CNT, 32'h0);
      rd_chk(4'h2, 32'h0);
   endtask
   task automatic t_force;
      wait_sync(1'b1, 10000);
      wr(OFS_CMD, 32'h1);
      repeat (2) @(posedge clk);
      chk(sync, 1'b0);
      wait_sync(1'b1, 10000);
   endtask
   // Four bad check words in a row must be counted, flagged and drop sync.
   task automatic t_crc;
      bad <= 1'b1;
      wait_sync(1'b0, 30000);
      bad <= 1'b0;
      rd_chk(OFS_CRC_CNT, 32'h4);
      rd_chk(OFS_STATUS, 32'h2);
      wr(OFS_STATUS, 32'h2);
      rd_chk(OFS_STATUS, 32'h0);
   endtask
   task automatic t_mode1;
      int hit;
      wr(OFS_CTRL, 32'h5);
      wait_sync(1'b1, 25000);
      chk(n > 6000, 1'b1);
      bad <= 1'b1;
      // Rewriting the same format keeps sync, so the restart is forced.
      wr(OFS_CMD, 32'h1);
      repeat (2) @(posedge clk);
      hit = 0;
      repeat (14000) begin
         @(posedge clk);
         if (sync !== 1'b0) hit++;
      end
      chk(hit, 0);
   endtask
   task automatic t_f4;
      tx_on <= 1'b0;
      do_reset;
      fmt_f4 <= 1'b1;
      wr(OFS_CTRL, 32'h8);
      tx_on <= 1'b1;
      repeat (1600) @(posedge clk);
      rd_chk(OFS_CTRL, 32'h8);
   endtask
   task automatic end_of_test;
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 99000) begin
         err_total++;
         end_of_test;
      end
   end
   initial begin
      rst = 1'b1;
      bad = 1'b0;
      tx_on = 1'b0;
      fmt_f4 = 1'b0;
      bus = '0;
      err_total = 0;
      check_count = 0;
      cyc = 0;
      do_reset;
      tx_on <= 1'b1;
      t_regs;
      t_force;
      t_crc;
      t_mode1;
      t_f4;
      end_of_test;
   end
endmodule // tfr_framer_test
`default_nettype wire
